//--- design/priority_trap_and_privilege_unit.sv
// Purpose: Interrupt priority, internal traps and context switch sequencing
// Assumes: Decoder strobes one instruction at a time; memory acks each step
// Notes: Vector table at level*4: new workspace pointer then program counter
`timescale 1ns/1ps
`include "trap_unit_regs.svh"
// Contract
// RL1: Sixteen vectored prioritised interrupt levels
// RL2: Level 0 reset highest, 15 lowest
// RL3: Internal traps posted at level two
// RL4: NMI below reset, above one, unmaskable
// RL5: Switch saves and loads WP, ST, PC
// RL6: Unclaimed undefined opcode raises illegal trap
// RL7: Privileged op in user mode traps
// RL8: Privilege from one status bit only
// RL9: Twelve listed instructions are privileged
// RL10: Arithmetic overflow raises arithmetic fault
// RL11: Status bit enables overflow trap
// RL12: Fault switch right after instruction
// RL13: Accept highest allowed pending request only
// RL14: Violating instruction has no side effect
module priority_trap_and_privilege_unit #(
    parameter int LEVELS = `TU_LEVELS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [LEVELS-1:1] extRequest,
    input wire logic nmiRequest,
    input wire logic [15:0] status,
    input wire trap_unit_pkg::ctx_t oldCtx,
    input wire logic instrValid,
    input wire trap_unit_pkg::op_class_t opClass,
    input wire logic opUndefined,
    input wire logic opClaimed,
    input wire logic instrDone,
    input wire logic overflow,
    input wire logic memAck,
    output logic execAllow,
    output logic memValid,
    output trap_unit_pkg::mem_req_t memReq,
    output logic switchBusy,
    output logic switchDone,
    output logic [3:0] takenLevel,
    output logic takenNmi,
    output logic [15:0] newWp,
    output logic [15:0] newPc,
    output logic [15:0] newSt
);
    import trap_unit_pkg::*;
    if (LEVELS != 16) begin : g_bad_levels
        $error("unit supports exactly 16 levels");
    end
    // ==========================================================
    // Trap detection
    logic privMode;
    logic isPrivOp;
    logic privTrap;
    logic illegalTrap;
    logic faultTrap;
    logic trapPending;
    logic next_trapPending;
    csw_state_t state;
    logic [3:0] acceptedLevel;
    logic acceptedNmi;
    // RL8 single status bit
    assign privMode = status[`TU_ST_PRIV_BIT];
    // RL9 privileged set
    assign isPrivOp = (opClass != OP_OTHER);
    // RL7 user mode violation
    assign privTrap = instrValid && isPrivOp && !privMode;
    // RL6 unclaimed undefined opcode
    assign illegalTrap = instrValid && opUndefined && !opClaimed;
    // RL10 RL11 overflow gated by enable bit
    assign faultTrap = instrDone && overflow && status[`TU_ST_OVEN_BIT];
    // RL14 block execution on violation
    assign execAllow = instrValid && !privTrap && !illegalTrap;
    always_comb begin
        next_trapPending = trapPending;
        if (state == S_DONE && acceptedLevel == `TU_LEVEL_TRAP
            && !acceptedNmi) begin
            next_trapPending = 1'b0;
        end
        // Set wins over the clear
        if (privTrap || illegalTrap || faultTrap) begin
            next_trapPending = 1'b1;
        end
    end
    // ==========================================================
    // Level selection
    logic [LEVELS-1:0] pending;
    logic pickFound;
    logic [3:0] pickLevel;
    csw_state_t next_state;
    logic [3:0] next_acceptedLevel;
    logic next_acceptedNmi;
    logic [15:0] vecBase;
    // RL3 traps share level two
    always_comb begin
        pending = {extRequest, 1'b0};
        pending[`TU_LEVEL_TRAP] = extRequest[`TU_LEVEL_TRAP] || trapPending;
        // RL2 level 0 only via reset
        pending[`TU_LEVEL_RESET] = 1'b0;
    end
    level_picker #(.LEVELS(LEVELS)) picker (
        .pending(pending),
        .mask(status[`TU_ST_MASK_LSB +: 4]),
        .found(pickFound),
        .level(pickLevel)
    );
    // RL1 own vector per level
    assign vecBase = acceptedNmi ? `TU_VEC_NMI
                   : {10'h000, acceptedLevel, 2'h0};
    // ==========================================================
    // Context switch sequencer
    ctx_t saved;
    ctx_t next_saved;
    logic [15:0] next_newWp;
    logic [15:0] next_newPc;
    logic [15:0] next_newSt;
    logic [15:0] memRdata;
    // Read data comes back on the workspace field of the context input
    assign memRdata = oldCtx.wp;
    always_comb begin
        next_state = state;
        next_acceptedLevel = acceptedLevel;
        next_acceptedNmi = acceptedNmi;
        next_saved = saved;
        next_newWp = newWp;
        next_newPc = newPc;
        next_newSt = newSt;
        case (state)
            S_IDLE: begin
                // RL12 RL13 RL4 start between instructions, NMI first
                if ((nmiRequest || pickFound || faultTrap) && !instrValid) begin
                    next_acceptedNmi = nmiRequest;
                    next_acceptedLevel = nmiRequest ? `TU_LEVEL_ONE
                                       : (pickFound ? pickLevel
                                                    : `TU_LEVEL_TRAP);
                    next_saved = oldCtx;
                    next_state = S_LOAD_WP;
                end
            end
            // RL5 fetch new WP then PC, then store old vector
            S_LOAD_WP: begin
                if (memAck) begin
                    next_newWp = memRdata;
                    next_state = S_LOAD_PC;
                end
            end
            S_LOAD_PC: begin
                if (memAck) begin
                    next_newPc = memRdata;
                    next_state = S_SAVE_WP;
                end
            end
            S_SAVE_WP: begin
                if (memAck) begin
                    next_state = S_SAVE_PC;
                end
            end
            S_SAVE_PC: begin
                if (memAck) begin
                    next_state = S_SAVE_ST;
                end
            end
            S_SAVE_ST: begin
                if (memAck) begin
                    next_newSt = saved.st;
                    next_state = S_DONE;
                end
            end
            S_DONE: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end
    always_comb begin
        memValid = (state != S_IDLE) && (state != S_DONE);
        memReq = '0;
        case (state)
            S_LOAD_WP: memReq = '{write: 1'b0, addr: vecBase, data: 16'h0};
            S_LOAD_PC: memReq = '{write: 1'b0, addr: vecBase + 16'h0002,
                                  data: 16'h0};
            S_SAVE_WP: memReq = '{write: 1'b1, addr: newWp + 16'h001A,
                                  data: saved.wp};
            S_SAVE_PC: memReq = '{write: 1'b1, addr: newWp + 16'h001C,
                                  data: saved.pc};
            S_SAVE_ST: memReq = '{write: 1'b1, addr: newWp + 16'h001E,
                                  data: saved.st};
            default: memReq = '0;
        endcase
    end
    assign switchBusy = (state != S_IDLE);
    assign switchDone = (state == S_DONE);
    assign takenLevel = acceptedLevel;
    assign takenNmi = acceptedNmi;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= S_IDLE;
            trapPending <= 1'b0;
            acceptedLevel <= `TU_LEVEL_RESET;
            acceptedNmi <= 1'b0;
            saved <= '0;
            newWp <= 16'h0000;
            newPc <= 16'h0000;
            newSt <= `TU_ST_RESET;
        end else begin
            state <= next_state;
            trapPending <= next_trapPending;
            acceptedLevel <= next_acceptedLevel;
            acceptedNmi <= next_acceptedNmi;
            saved <= next_saved;
            newWp <= next_newWp;
            newPc <= next_newPc;
            newSt <= next_newSt;
        end
    end
    // ==========================================================
    // Checks
    a_priv_block: assert property ( // RL7
        @(posedge clock) disable iff (!rst_n)
        (instrValid && isPrivOp && !status[`TU_ST_PRIV_BIT]) |-> !execAllow)
        else $error("privileged op executed in user mode");
    a_priv_allow: assert property ( // RL8
        @(posedge clock) disable iff (!rst_n)
        (instrValid && !opUndefined && status[`TU_ST_PRIV_BIT]) |-> execAllow)
        else $error("privileged mode op refused");
    a_illegal_post: assert property ( // RL6
        @(posedge clock) disable iff (!rst_n)
        (instrValid && opUndefined && !opClaimed) |=> trapPending)
        else $error("illegal opcode not posted");
    a_fault_post: assert property ( // RL10
        @(posedge clock) disable iff (!rst_n)
        (instrDone && overflow && status[`TU_ST_OVEN_BIT]) |=> trapPending)
        else $error("overflow not posted");
    a_fault_gate: assert property ( // RL11
        @(posedge clock) disable iff (!rst_n)
        (!trapPending && !instrValid && instrDone && overflow
         && !status[`TU_ST_OVEN_BIT]) |=> !trapPending)
        else $error("overflow trapped while disabled");
    a_nmi_first: assert property ( // RL4
        @(posedge clock) disable iff (!rst_n)
        (state == S_IDLE && nmiRequest && !instrValid) |=> takenNmi)
        else $error("nmi not taken first");
    a_switch_order: assert property ( // RL5
        @(posedge clock) disable iff (!rst_n)
        (state == S_LOAD_WP && memAck) |=> state == S_LOAD_PC)
        else $error("context switch out of order");
    a_trap_level: assert property ( // RL12
        @(posedge clock) disable iff (!rst_n)
        (state == S_IDLE && !nmiRequest && !pickFound && faultTrap
         && !instrValid) |=> takenLevel == `TU_LEVEL_TRAP)
        else $error("fault not at trap level");
    a_mask_obey: assert property ( // RL13
        @(posedge clock) disable iff (!rst_n)
        (state == S_IDLE && pickFound && !nmiRequest && !instrValid)
        |=> takenLevel <= $past(status[3:0]))
        else $error("masked level accepted");
    c_nmi: cover property (@(posedge clock) disable iff (!rst_n)
        state == S_DONE && takenNmi);
    c_trap: cover property (@(posedge clock) disable iff (!rst_n)
        state == S_DONE && takenLevel == `TU_LEVEL_TRAP);
    c_priv: cover property (@(posedge clock) disable iff (!rst_n) privTrap);
endmodule : priority_trap_and_privilege_unit

//--- design/trap_unit_regs.svh
// Purpose: Constants for the priority, trap and privilege unit
// Assumes: Included by the package and by the top design module
// Notes: Definitions only
`ifndef TRAP_UNIT_REGS_SVH
`define TRAP_UNIT_REGS_SVH
`define TU_LEVELS 16
`define TU_LEVEL_RESET 4'h0
`define TU_LEVEL_ONE 4'h1
`define TU_LEVEL_TRAP 4'h2
`define TU_LEVEL_LAST 4'hF
`define TU_ST_PRIV_BIT 8
`define TU_ST_OVEN_BIT 5
`define TU_ST_MASK_LSB 0
`define TU_ST_RESET 16'h0100
`define TU_VEC_NMI 16'hFFFC
`define TU_CSW_STEPS 6
`endif

//--- design/trap_unit_pkg.sv
// Purpose: Types for the priority, trap and privilege unit
// Assumes: trap_unit_regs.svh provides the constants
// Notes: Holds the instruction class, the state enum and the save struct
`include "trap_unit_regs.svh"
package trap_unit_pkg;
    // ==========================================================
    // Instruction classes from the decoder
    typedef enum logic [3:0] {
        OP_OTHER = 4'h0, ext_clock_on_op = 4'h1, ext_clock_off_op = 4'h2,
        OP_IDLE = 4'h3, mask_load_immediate_op = 4'h4,
        load_external_op = 4'h5, external_reset_op = 4'h6,
        serial_io_load_op = 4'h7, io_bit_set_op = 4'h8,
        io_bit_clear_op = 4'h9, map_file_load_op = 4'hA,
        far_destination_op = 4'hB, far_source_op = 4'hC
    } op_class_t;
    // ==========================================================
    // Context switch sequencer states
    typedef enum logic [7:0] {
        S_IDLE = 8'h01, S_SAVE_WP = 8'h02, S_SAVE_PC = 8'h04,
        S_SAVE_ST = 8'h08, S_LOAD_WP = 8'h10, S_LOAD_PC = 8'h20,
        S_DONE = 8'h40
    } csw_state_t;
    // ==========================================================
    // Old state vector handed in by the core
    typedef struct packed {
        logic [15:0] wp;
        logic [15:0] pc;
        logic [15:0] st;
    } ctx_t;
    // Bus step request to the memory side
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } mem_req_t;
endpackage : trap_unit_pkg

//--- design/level_picker.sv
// Purpose: Picks the highest allowed pending interrupt level
// Assumes: Level 0 is highest priority, mask gives lowest admitted
// Notes: Pure combinational, reset level always admitted
`timescale 1ns/1ps
module level_picker #(
    parameter int LEVELS = 16
) (
    input wire logic [LEVELS-1:0] pending,
    input wire logic [3:0] mask,
    output logic found,
    output logic [3:0] level
);
    if (LEVELS != 16) begin : g_bad_levels
        $error("level_picker supports exactly 16 levels");
    end
    // ==========================================================
    // Priority scan
    always_comb begin
        found = 1'b0;
        level = 4'h0;
        for (int i = LEVELS - 1; i >= 0; i--) begin
            // RL13 mask admits level
            if (pending[i] && (i == 0 || i[3:0] <= mask)) begin
                found = 1'b1;
                level = i[3:0];
            end
        end
    end
endmodule : level_picker

//--- bench/mem_partner.sv
// Purpose: Memory side model answering context switch steps
// Assumes: One step stands on memReq until memAck
// Notes: Reads return addr+1000h, log keeps last three writes
`timescale 1ns/1ps
module mem_partner (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic memValid,
    input wire trap_unit_pkg::mem_req_t memReq,
    output logic memAck,
    output logic [15:0] rdata,
    output logic [2:0][15:0] wrAddr,
    output logic [2:0][15:0] wrData,
    output int wrCount
);
    import trap_unit_pkg::*;
    int waitCnt;
    // ====
    // Read data: undriven bus shows a changing pattern, not stale data
    assign rdata = (memValid && !memReq.write) ? memReq.addr + 16'h1000
                                               : ~(memReq.addr + 16'h1000);
    // ====
    // Ack: one pulse per step, optional wait states
    always @(posedge clock) begin
        if (!rst_n) begin
            memAck <= 1'b0;
            waitCnt <= 0;
            wrCount <= 0;
        end else if (memAck || !memValid) begin
            memAck <= 1'b0;
            waitCnt <= 0;
        end else if (waitCnt < (slow ? 3 : 0)) begin
            waitCnt <= waitCnt + 1;
        end else begin
            memAck <= 1'b1;
            if (memReq.write) begin
                wrAddr <= {memReq.addr, wrAddr[2:1]};
                wrData <= {memReq.data, wrData[2:1]};
                wrCount <= wrCount + 1;
            end
        end
    end
endmodule : mem_partner

//--- bench/testbench.sv
// Purpose: Self-checking bench for the trap and priority unit
// Assumes: Inputs change on falling edges
// Notes: Expected vectors are worked out from level*4 and NMI vector
`timescale 1ns/1ps
`include "trap_unit_regs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
    import trap_unit_pkg::*;
    localparam logic [15:0] OLDWP = 16'h2340;
    localparam logic [15:0] OLDPC = 16'h4566;
    logic clock = 0, rst_n = 0, nmiRequest = 0, instrValid = 0;
    logic opUndefined = 0, opClaimed = 0, instrDone = 0, overflow = 0;
    logic slow = 0, memAck, execAllow, memValid, switchBusy, switchDone;
    logic takenNmi;
    logic [15:1] extRequest = '0;
    logic [15:0] status = 16'h0000, rdata, newWp, newPc, newSt;
    logic [3:0] takenLevel;
    logic [2:0][15:0] wrAddr, wrData;
    op_class_t opClass = OP_OTHER;
    ctx_t oldCtx;
    mem_req_t memReq;
    int mismatches = 0, num_checks = 0, wrCount;
    assign oldCtx = '{wp: (memValid && !memReq.write) ? rdata : OLDWP,
                      pc: OLDPC, st: status};
    priority_trap_and_privilege_unit u_priority_trap_and_privilege_unit (
        .clock(clock), .rst_n(rst_n), .extRequest(extRequest),
        .nmiRequest(nmiRequest), .status(status), .oldCtx(oldCtx),
        .instrValid(instrValid), .opClass(opClass),
        .opUndefined(opUndefined), .opClaimed(opClaimed),
        .instrDone(instrDone), .overflow(overflow), .memAck(memAck),
        .execAllow(execAllow), .memValid(memValid), .memReq(memReq),
        .switchBusy(switchBusy), .switchDone(switchDone),
        .takenLevel(takenLevel), .takenNmi(takenNmi), .newWp(newWp),
        .newPc(newPc), .newSt(newSt));
    mem_partner u_mem_partner (.clock(clock), .rst_n(rst_n), .slow(slow),
        .memValid(memValid), .memReq(memReq), .memAck(memAck),
        .rdata(rdata), .wrAddr(wrAddr), .wrData(wrData), .wrCount(wrCount));
    initial begin
        forever #2.5 clock = ~clock;
    end
    function automatic logic [15:0] st(logic p, logic v, logic [3:0] m);
        logic [15:0] s;
        s = '0;
        s[`TU_ST_PRIV_BIT] = p;
        s[`TU_ST_OVEN_BIT] = v;
        s[3:0] = m;
        return s;
    endfunction : st
    // ====
    // Shared checks
    task automatic check_switch(logic [3:0] lvl, logic nmi);
        logic [15:0] vec;
        int n0;
        n0 = wrCount;
        vec = nmi ? `TU_VEC_NMI : {10'h0, lvl, 2'b00};
        for (int i = 0; i < 100 && switchDone !== 1'b1; i++) @(negedge clock);
        `CHK("done", 1'b1, switchDone)
        `CHK("level", lvl, takenLevel)
        `CHK("nmi", nmi, takenNmi)
        `CHK("wp", vec + 16'h1000, newWp)
        `CHK("pc", vec + 16'h1002, newPc)
        `CHK("st", status, newSt)
        `CHK("writes", n0 + 3, wrCount)
        `CHK("wa", vec + 16'h101E, wrAddr[2])
        `CHK("wdata", {status, OLDPC, OLDWP}, wrData)
        @(negedge clock);
    endtask : check_switch
    task automatic no_switch();
        logic seen;
        seen = 0;
        repeat (30) @(negedge clock) seen |= switchBusy;
        `CHK("quiet", 1'b0, seen)
    endtask : no_switch
    task automatic instr(op_class_t c, logic u, logic cl, logic allow);
        opClass = c;
        opUndefined = u;
        opClaimed = cl;
        instrValid = 1;
        #1 `CHK("allow", allow, execAllow)
        @(negedge clock);
        instrValid = 0;
        opUndefined = 0;
        opClaimed = 0;
        opClass = OP_OTHER;
        @(negedge clock);
    endtask : instr
    // ====
    // Scenarios
    task automatic t_priority();
        status = st(1, 0, 4'hF);
        // Levels 3 and 7 together
        extRequest = 15'h0044;
        check_switch(4'h3, 0);
        extRequest[3] = 0;
        check_switch(4'h7, 0);
        slow = 1;
        // Level 15 alone
        extRequest = 15'h4000;
        check_switch(4'hF, 0);
        extRequest = '0;
        slow = 0;
    endtask : t_priority
    task automatic t_mask();
        status = st(1, 0, 4'h5);
        // Levels 6 and 9, both above mask 5
        extRequest = 15'h0120;
        no_switch();
        status = st(1, 0, 4'hF);
        check_switch(4'h6, 0);
        extRequest = '0;
    endtask : t_mask
    task automatic t_nmi();
        status = st(1, 0, 4'h0);
        extRequest[1] = 1;
        nmiRequest = 1;
        check_switch(4'h1, 1);
        nmiRequest = 0;
        no_switch();
        extRequest = '0;
    endtask : t_nmi
    task automatic t_priv();
        status = st(0, 0, 4'hF);
        for (int c = 1; c <= 12; c++) begin
            instr(op_class_t'(c), 0, 0, 0);
            check_switch(`TU_LEVEL_TRAP, 0);
        end
        instr(OP_OTHER, 0, 0, 1);
        status = st(1, 0, 4'hF);
        instr(OP_IDLE, 0, 0, 1);
        no_switch();
    endtask : t_priv
    task automatic t_illegal();
        status = st(1, 0, 4'hF);
        instr(OP_OTHER, 1, 0, 0);
        check_switch(`TU_LEVEL_TRAP, 0);
        instr(OP_OTHER, 1, 1, 1);
        no_switch();
    endtask : t_illegal
    task automatic t_overflow();
        logic seen;
        seen = 0;
        status = st(1, 1, 4'hF);
        instrDone = 1;
        overflow = 1;
        @(negedge clock);
        instrDone = 0;
        overflow = 0;
        repeat (3) @(negedge clock) seen |= memValid;
        `CHK("prompt", 1'b1, seen)
        check_switch(`TU_LEVEL_TRAP, 0);
        status = st(1, 0, 4'hF);
        instrDone = 1;
        overflow = 1;
        @(negedge clock);
        instrDone = 0;
        overflow = 0;
        no_switch();
    endtask : t_overflow
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (10) @(negedge clock);
        rst_n = 1;
        @(negedge clock);
        t_priority();
        t_mask();
        t_nmi();
        t_priv();
        t_illegal();
        t_overflow();
        summarize();
    end
    initial begin
        #200us;
        mismatches++;
        summarize();
    end
endmodule : testbench
